// >>> dv/csd_host_model.sv
// board straps and host serial controller driving the strap comparators
`timescale 1ns/1ns
module csd_host_model (
  input  wire logic ref_clk,
  output logic      fs_above,
  output logic      fs_below,
  output logic      sw_above,
  output logic      sw_below,
  output logic      ed_above,
  output logic      ed_below,
  output logic      cd_above,
  output logic      cd_below
);
  csd_pkg::csd_level_e lvl [4] = '{default: csd_pkg::CSD_LVL_HIGH};

  function automatic logic [1:0] drv(input csd_pkg::csd_level_e l);
    return {l == csd_pkg::CSD_LVL_HIGH, l == csd_pkg::CSD_LVL_LOW};
  endfunction : drv

  assign {fs_above, fs_below} = drv(lvl[0]);
  assign {sw_above, sw_below} = drv(lvl[1]);
  assign {ed_above, ed_below} = drv(lvl[2]);
  assign {cd_above, cd_below} = drv(lvl[3]);

  // two bits a pin: mode, swing, edge, delay; callers never float the delay pin
  task automatic set_straps(input logic [7:0] c);
    @(posedge ref_clk);
    lvl[0] <= csd_pkg::csd_level_e'(c[7:6]);
    lvl[1] <= csd_pkg::csd_level_e'(c[5:4]);
    lvl[2] <= csd_pkg::csd_level_e'(c[3:2]);
    lvl[3] <= csd_pkg::csd_level_e'(c[1:0]);
  endtask : set_straps

  // one frame, msb first; clock idles low, data inverted once released
  task automatic write_ureg(input logic [3:0] a, input logic [11:0] d);
    logic [15:0] f;
    f = {a, d};
    @(posedge ref_clk);
    lvl[3] <= csd_pkg::CSD_LVL_LOW;
    for (int i = 15; i >= 0; i--) begin
      lvl[1] <= csd_pkg::CSD_LVL_LOW;
      lvl[2] <= f[i] ? csd_pkg::CSD_LVL_HIGH : csd_pkg::CSD_LVL_LOW;
      repeat (3) @(posedge ref_clk);
      lvl[1] <= csd_pkg::CSD_LVL_HIGH;
      repeat (3) @(posedge ref_clk);
    end
    lvl[1] <= csd_pkg::CSD_LVL_LOW;
    repeat (3) @(posedge ref_clk);
    lvl[3] <= csd_pkg::CSD_LVL_HIGH;
    lvl[2] <= f[0] ? csd_pkg::CSD_LVL_LOW : csd_pkg::CSD_LVL_HIGH;
    repeat (10) @(posedge ref_clk);
  endtask : write_ureg
endmodule : csd_host_model

// >>> dv/tb_top.sv
// self-checking bench for the control mode strap decoder
`timescale 1ns/1ns
module tb_top;
  logic        ref_clk   = 1'b0;
  logic        rst       = 1'b1;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_write = 1'b0;
  logic        reg_read  = 1'b0;
  logic        fa, fb, sa, sb, ea, eb, ca, cb;
  logic        ext, cv, swing, out_edge, ddr, cal_dly, fs_lvl, cal_start;
  logic [31:0] reg_rdata;
  logic [11:0] fs_code, ofs_code;
  logic [17:0] outs;
  logic [7:0]  strap_tab [4] = '{8'h00, 8'h55, 8'h48, 8'h61};
  logic [17:0] exp_tab   [4] = '{18'h00600, 18'h1b800, 18'h0d800, 18'h03800};
  int          fail_count  = 0;
  int          checks_done = 0;
  int          cycles      = 0;

  assign outs = {ext, swing, out_edge, ddr, cal_dly, fs_lvl, fs_code};
  always #5 ref_clk = ~ref_clk;

  csd_host_model i_csd_host_model (.ref_clk(ref_clk), .fs_above(fa), .fs_below(fb), .sw_above(sa),
    .sw_below(sb), .ed_above(ea), .ed_below(eb), .cd_above(ca), .cd_below(cb));

  csd_top i_csd_top (.ref_clk(ref_clk), .rst(rst), .full_scale_select_pin_above(fa),
    .full_scale_select_pin_below(fb), .swing_select_pin_above(sa), .swing_select_pin_below(sb),
    .edge_select_pin_above(ea), .edge_select_pin_below(eb), .cal_delay_pin_above(ca),
    .cal_delay_pin_below(cb), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .extended_mode(ext), .config_valid(cv),
    .output_swing_level(swing), .output_launch_edge(out_edge), .output_ddr_mode(ddr),
    .calibration_delay_select(cal_dly), .input_full_scale_level(fs_lvl), .full_scale_code(fs_code),
    .offset_code(ofs_code), .calibration_start(cal_start));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
    #1;
  endtask : bus_write

  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : bus_read

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      stop_test();
    end
  end

  initial begin
    logic [31:0] st;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    check("reset outputs", 32'h19800, outs);
    for (int i = 0; i < 4; i++) begin
      i_csd_host_model.set_straps(strap_tab[i]);
      repeat (30) @(posedge ref_clk);
      #1;
      check("strap outputs", exp_tab[i], outs);
      if (i == 1) begin
        bus_write(8'h04, 32'h1);
        check("pin calibration", 1'b1, cal_start);
      end
    end
    bus_read(8'h00, st);
    check("strap status", 32'h4904, st & 32'hff04);
    bus_read(8'h20, st);
    check("unmapped read", 32'h0, st);
    i_csd_host_model.set_straps(8'h81);
    repeat (40) @(posedge ref_clk);
    bus_write(8'h04, 32'h1);
    check("refused calibration", 1'b0, cal_start);
    bus_read(8'h00, st);
    check("extended status", 32'h11, st & 32'h1b);
    i_csd_host_model.write_ureg(4'h0, 12'h01b);
    i_csd_host_model.write_ureg(4'h3, 12'hfff);
    i_csd_host_model.write_ureg(4'h1, 12'h9a5);
    check("partial valid", 1'b0, cv);
    i_csd_host_model.write_ureg(4'h2, 12'h0c3);
    check("serial outputs", 32'h3b9a5, outs);
    check("offset code", 32'h0c3, ofs_code);
    check("all written valid", 1'b1, cv);
    bus_read(8'h0c, st);
    check("full scale mirror", 32'h9a5, st);
    bus_write(8'h04, 32'h1);
    check("ext calibration", 1'b1, cal_start);
    bus_write(8'h04, 32'h2);
    bus_read(8'h00, st);
    check("refused cleared", 32'hb, st & 32'h1b);
    stop_test();
  end
endmodule : tb_top

// >>> hw/csd_defines.svh
// constants for the control mode strap decoder
`ifndef CSD_DEFINES_SVH
`define CSD_DEFINES_SVH

// strap settling and serial frame
`define CSD_STABLE_CYCLES 4'h8
`define CSD_FRAME_BITS    5'h10
`define CSD_FRM_ADDR_MSB  15
`define CSD_FRM_ADDR_LSB  12
`define CSD_FRM_DATA_MSB  11

// register bus map
`define CSD_ADDR_STATUS 8'h00
`define CSD_ADDR_CTRL   8'h04
`define CSD_ADDR_UREG0  8'h08
`define CSD_ADDR_UREG1  8'h0c
`define CSD_ADDR_UREG2  8'h10

// control register bits
`define CSD_CTRL_CAL_BIT   0
`define CSD_CTRL_CLEAR_BIT 1

// status register bits
`define CSD_ST_EXT_BIT     0
`define CSD_ST_VALID_BIT   1
`define CSD_ST_FAULT_BIT   2
`define CSD_ST_ALLWR_BIT   3
`define CSD_ST_REFUSE_BIT  4
`define CSD_ST_MODE_LSB    8
`define CSD_ST_SWING_LSB   10
`define CSD_ST_EDGE_LSB    12
`define CSD_ST_CAL_LSB     14

// user registers
`define CSD_UREG_CFG    2'h0
`define CSD_UREG_FS     2'h1
`define CSD_UREG_OFS    2'h2
`define CSD_UREG_COUNT  2'h3
`define CSD_UREG_ALL    3'h7
`define CSD_UREG_RESET  12'h000
`define CSD_CFG_SWING   0
`define CSD_CFG_EDGE    1
`define CSD_CFG_DDR     2
`define CSD_CFG_CALIBRATION_DELAY_SELECT  3
`define CSD_CFG_FSR     4

// full-scale codes used while straps are in control
`define CSD_FS_NORMAL   12'h800
`define CSD_FS_REDUCED  12'h600
`define CSD_OFS_ZERO    12'h000

`endif

// >>> hw/csd_pkg.sv
// types shared by the control mode strap decoder
package csd_pkg;

  typedef enum logic [1:0] {
    CSD_LVL_LOW   = 2'b00,
    CSD_LVL_HIGH  = 2'b01,
    CSD_LVL_FLOAT = 2'b10
  } csd_level_e;

  typedef enum logic [1:0] {
    CSD_MODE_RESOLVE = 2'b00,
    CSD_MODE_PIN     = 2'b01,
    CSD_MODE_EXT     = 2'b10
  } csd_mode_e;

  typedef logic [11:0] csd_word_t;

  // window comparator outputs to a level; neither threshold crossed means floating
  function automatic csd_level_e csd_decode(input logic above, input logic below);
    if (above) begin
      return CSD_LVL_HIGH;
    end else if (below) begin
      return CSD_LVL_LOW;
    end
    return CSD_LVL_FLOAT;
  endfunction : csd_decode

endpackage : csd_pkg

// >>> hw/csd_serial_port.sv
// serial register port: frames of address and data clocked in on serial clock rises
`timescale 1ns/1ns
`include "csd_defines.svh"
module csd_serial_port (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              port_enable,
  input  wire logic              serial_clock_level,
  input  wire logic              serial_port_data,
  input  wire logic              serial_port_select_n,
  output logic                   write_pulse,
  output logic [1:0]             write_index,
  output csd_pkg::csd_word_t     write_data
);
  logic        sclk_prev_reg;
  logic        sel_prev_reg;
  logic [15:0] shift_reg;
  logic [4:0]  count_reg;
  logic        pulse_reg;
  logic        selected;
  logic        frame_end;

  assign selected  = port_enable && !serial_port_select_n;
  assign frame_end = sel_prev_reg && !selected;

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sclk_prev_reg <= 1'b0;
      sel_prev_reg  <= 1'b0;
    end else begin
      sclk_prev_reg <= serial_clock_level;
      sel_prev_reg  <= selected;
    end
  end

  // bits beyond one frame are dropped; a short frame writes nothing
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shift_reg <= 16'h0000;
      count_reg <= 5'h00;
    end else if (!selected) begin
      count_reg <= 5'h00;
    end else if (serial_clock_level && !sclk_prev_reg && count_reg != `CSD_FRAME_BITS) begin
      shift_reg <= {shift_reg[14:0], serial_port_data};
      count_reg <= count_reg + 5'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pulse_reg <= 1'b0;
    end else begin
      pulse_reg <= port_enable && frame_end && count_reg == `CSD_FRAME_BITS
                   && shift_reg[`CSD_FRM_ADDR_MSB:`CSD_FRM_ADDR_LSB] < {2'h0, `CSD_UREG_COUNT};
    end
  end

  assign write_pulse = pulse_reg;
  assign write_index = shift_reg[`CSD_FRM_ADDR_LSB+1:`CSD_FRM_ADDR_LSB];
  assign write_data  = shift_reg[`CSD_FRM_DATA_MSB:0];

  //////////////////////////////////////////////////////////////////////////////
  a_port_idle: assert property (@(posedge ref_clk) disable iff (rst)
    !port_enable |-> ##1 !write_pulse)
    else $error("serial write while port disabled");

endmodule : csd_serial_port

// >>> hw/csd_strap_resolver.sv
// resolves one three-level strap pin to a settled code
`timescale 1ns/1ns
`include "csd_defines.svh"
module csd_strap_resolver (
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic               pin_above,
  input  wire logic               pin_below,
  output logic                    level_sync,
  output csd_pkg::csd_level_e     level_code,
  output logic                    level_valid
);
  logic                above_meta_reg;
  logic                above_sync_reg;
  logic                below_meta_reg;
  logic                below_sync_reg;
  csd_pkg::csd_level_e cand;
  csd_pkg::csd_level_e last_reg;
  logic [3:0]          count_reg;
  csd_pkg::csd_level_e code_reg;
  logic                valid_reg;

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      above_meta_reg <= 1'b0;
      above_sync_reg <= 1'b0;
      below_meta_reg <= 1'b0;
      below_sync_reg <= 1'b0;
    end else begin
      above_meta_reg <= pin_above;
      above_sync_reg <= above_meta_reg;
      below_meta_reg <= pin_below;
      below_sync_reg <= below_meta_reg;
    end
  end

  assign cand = csd_pkg::csd_decode(above_sync_reg, below_sync_reg);

  // a level must hold for the settle count before it is taken
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      last_reg  <= csd_pkg::CSD_LVL_LOW;
      count_reg <= 4'h0;
      code_reg  <= csd_pkg::CSD_LVL_LOW;
      valid_reg <= 1'b0;
    end else begin
      if (cand != last_reg) begin
        last_reg  <= cand;
        count_reg <= 4'h0;
      end else if (count_reg != `CSD_STABLE_CYCLES) begin
        count_reg <= count_reg + 4'h1;
      end else begin
        code_reg  <= last_reg;
        valid_reg <= 1'b1;
      end
    end
  end

  assign level_sync  = above_sync_reg;
  assign level_code  = code_reg;
  assign level_valid = valid_reg;

  //////////////////////////////////////////////////////////////////////////////
  a_code_settled: assert property (@(posedge ref_clk) disable iff (rst)
    (code_reg != $past(code_reg)) |-> ($past(count_reg) == `CSD_STABLE_CYCLES && $past(last_reg) == code_reg))
    else $error("strap code changed before settling");

endmodule : csd_strap_resolver

// >>> hw/csd_top.sv
// control mode strap decoder: straps or serial port select the converter setup
//
// Behaviour
// - A driven mode-select pin selects pin-controlled mode and only a floating one selects extended mode.
// - In pin-controlled mode the serial port is idle and every setting except the offset code, held at zero, comes from the strap levels.
// - In pin-controlled mode the mode-select pin low gives the reduced input range and high the normal range.
// - In pin-controlled mode the swing pin low gives reduced swing and high normal swing; floating is invalid.
// - In pin-controlled mode the edge pin high launches data on the rising clock edge and low on the falling.
// - A floating edge pin in pin-controlled mode gives a double-data-rate output clock using both edges.
// - The calibration-delay pin low selects the short delay and high the long; it must never float.
// - In extended mode the swing, edge and delay pins become serial clock, serial data and serial select.
// - Full scale is set only by the range strap or the full-scale adjust register, never by the reference pin.
`timescale 1ns/1ns
`include "csd_defines.svh"
module csd_top (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        full_scale_select_pin_above,
  input  wire logic        full_scale_select_pin_below,
  input  wire logic        swing_select_pin_above,
  input  wire logic        swing_select_pin_below,
  input  wire logic        edge_select_pin_above,
  input  wire logic        edge_select_pin_below,
  input  wire logic        cal_delay_pin_above,
  input  wire logic        cal_delay_pin_below,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  output logic             extended_mode,
  output logic             config_valid,
  output logic             output_swing_level,
  output logic             output_launch_edge,
  output logic             output_ddr_mode,
  output logic             calibration_delay_select,
  output logic             input_full_scale_level,
  output logic      [11:0] full_scale_code,
  output logic      [11:0] offset_code,
  output logic             calibration_start
);
  csd_pkg::csd_level_e mode_code;
  csd_pkg::csd_level_e swing_code;
  csd_pkg::csd_level_e edge_code;
  csd_pkg::csd_level_e cal_code;
  logic                mode_valid;
  logic                swing_valid;
  logic                edge_valid;
  logic                cal_valid;
  logic                swing_sync;
  logic                edge_sync;
  logic                cal_sync;
  logic                straps_valid;
  logic                ser_write;
  logic [1:0]          ser_index;
  csd_pkg::csd_word_t  ser_data;
  csd_pkg::csd_mode_e  mode_reg;
  csd_pkg::csd_mode_e  mode_next;
  csd_pkg::csd_word_t  ureg_reg [3];
  logic [2:0]          written_reg;
  logic                fault_reg;
  logic                refused_reg;
  logic                cal_reg;
  logic                cal_req;
  logic [31:0]         rdata_reg;
  logic [31:0]         status_word;

  //////////////////////////////////////////////////////////////////////////////
  // strap resolution
  csd_strap_resolver u_mode (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .pin_above   (full_scale_select_pin_above),
    .pin_below   (full_scale_select_pin_below),
    .level_sync  (),
    .level_code  (mode_code),
    .level_valid (mode_valid)
  );
  csd_strap_resolver u_swing (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .pin_above   (swing_select_pin_above),
    .pin_below   (swing_select_pin_below),
    .level_sync  (swing_sync),
    .level_code  (swing_code),
    .level_valid (swing_valid)
  );
  csd_strap_resolver u_edge (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .pin_above   (edge_select_pin_above),
    .pin_below   (edge_select_pin_below),
    .level_sync  (edge_sync),
    .level_code  (edge_code),
    .level_valid (edge_valid)
  );
  csd_strap_resolver u_cal (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .pin_above   (cal_delay_pin_above),
    .pin_below   (cal_delay_pin_below),
    .level_sync  (cal_sync),
    .level_code  (cal_code),
    .level_valid (cal_valid)
  );

  assign straps_valid = swing_valid && edge_valid && cal_valid;

  //////////////////////////////////////////////////////////////////////////////
  // serial port on the repurposed strap pins
  csd_serial_port u_serial (
    .ref_clk              (ref_clk),
    .rst                  (rst),
    .port_enable          (mode_reg == csd_pkg::CSD_MODE_EXT),
    .serial_clock_level   (swing_sync),
    .serial_port_data     (edge_sync),
    .serial_port_select_n (cal_sync),
    .write_pulse          (ser_write),
    .write_index          (ser_index),
    .write_data           (ser_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // mode selection
  always_comb begin
    mode_next = mode_reg;
    if (mode_valid) begin
      mode_next = (mode_code == csd_pkg::CSD_LVL_FLOAT) ? csd_pkg::CSD_MODE_EXT
                                                        : csd_pkg::CSD_MODE_PIN;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_reg <= csd_pkg::CSD_MODE_RESOLVE;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // user registers; the written set restarts whenever extended mode is entered
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ureg_reg[0] <= `CSD_UREG_RESET;
      ureg_reg[1] <= `CSD_UREG_RESET;
      ureg_reg[2] <= `CSD_UREG_RESET;
      written_reg <= 3'h0;
    end else if (mode_reg != csd_pkg::CSD_MODE_EXT) begin
      written_reg <= 3'h0;
    end else if (ser_write) begin
      ureg_reg[ser_index]    <= ser_data;
      written_reg[ser_index] <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // applied configuration
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      extended_mode            <= 1'b0;
      config_valid             <= 1'b0;
      output_swing_level       <= 1'b1;
      output_launch_edge       <= 1'b1;
      output_ddr_mode          <= 1'b0;
      calibration_delay_select <= 1'b0;
      input_full_scale_level   <= 1'b1;
      full_scale_code          <= `CSD_FS_NORMAL;
      offset_code              <= `CSD_OFS_ZERO;
      fault_reg                <= 1'b0;
    end else begin
      extended_mode <= (mode_reg == csd_pkg::CSD_MODE_EXT);
      unique case (mode_reg)
        csd_pkg::CSD_MODE_PIN: begin
          config_valid <= straps_valid;
          fault_reg    <= straps_valid && (swing_code == csd_pkg::CSD_LVL_FLOAT
                                           || cal_code == csd_pkg::CSD_LVL_FLOAT);
          input_full_scale_level <= (mode_code == csd_pkg::CSD_LVL_HIGH);
          full_scale_code <= (mode_code == csd_pkg::CSD_LVL_HIGH) ? `CSD_FS_NORMAL
                                                                  : `CSD_FS_REDUCED;
          offset_code     <= `CSD_OFS_ZERO;
          if (straps_valid && swing_code != csd_pkg::CSD_LVL_FLOAT) begin
            output_swing_level <= (swing_code == csd_pkg::CSD_LVL_HIGH);
          end
          if (straps_valid) begin
            output_ddr_mode <= (edge_code == csd_pkg::CSD_LVL_FLOAT);
            if (edge_code != csd_pkg::CSD_LVL_FLOAT) begin
              output_launch_edge <= (edge_code == csd_pkg::CSD_LVL_HIGH);
            end
          end
          if (straps_valid && cal_code != csd_pkg::CSD_LVL_FLOAT) begin
            calibration_delay_select <= (cal_code == csd_pkg::CSD_LVL_HIGH);
          end
        end
        csd_pkg::CSD_MODE_EXT: begin
          config_valid             <= (written_reg == `CSD_UREG_ALL);
          fault_reg                <= 1'b0;
          output_swing_level       <= ureg_reg[`CSD_UREG_CFG][`CSD_CFG_SWING];
          output_launch_edge       <= ureg_reg[`CSD_UREG_CFG][`CSD_CFG_EDGE];
          output_ddr_mode          <= ureg_reg[`CSD_UREG_CFG][`CSD_CFG_DDR];
          calibration_delay_select <= ureg_reg[`CSD_UREG_CFG][`CSD_CFG_CALIBRATION_DELAY_SELECT];
          input_full_scale_level   <= ureg_reg[`CSD_UREG_CFG][`CSD_CFG_FSR];
          full_scale_code          <= ureg_reg[`CSD_UREG_FS];
          offset_code              <= ureg_reg[`CSD_UREG_OFS];
        end
        csd_pkg::CSD_MODE_RESOLVE: begin
          config_valid <= 1'b0;
        end
        default: begin
          config_valid <= 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // calibration request from software, refused and flagged while the setup is incomplete
  assign cal_req = reg_write && reg_addr == `CSD_ADDR_CTRL && reg_wdata[`CSD_CTRL_CAL_BIT];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cal_reg     <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      cal_reg <= cal_req && config_valid;
      if (cal_req && !config_valid) begin
        refused_reg <= 1'b1;
      end else if (reg_write && reg_addr == `CSD_ADDR_CTRL && reg_wdata[`CSD_CTRL_CLEAR_BIT]) begin
        refused_reg <= 1'b0;
      end
    end
  end

  assign calibration_start = cal_reg;

  //////////////////////////////////////////////////////////////////////////////
  // register read port
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`CSD_ST_EXT_BIT]    = extended_mode;
    status_word[`CSD_ST_VALID_BIT]  = config_valid;
    status_word[`CSD_ST_FAULT_BIT]  = fault_reg;
    status_word[`CSD_ST_ALLWR_BIT]  = (written_reg == `CSD_UREG_ALL);
    status_word[`CSD_ST_REFUSE_BIT] = refused_reg;
    status_word[`CSD_ST_MODE_LSB+:2]  = mode_code;
    status_word[`CSD_ST_SWING_LSB+:2] = swing_code;
    status_word[`CSD_ST_EDGE_LSB+:2]  = edge_code;
    status_word[`CSD_ST_CAL_LSB+:2]   = cal_code;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (reg_read) begin
      unique case (reg_addr)
        `CSD_ADDR_STATUS: rdata_reg <= status_word;
        `CSD_ADDR_UREG0:  rdata_reg <= {20'h00000, ureg_reg[0]};
        `CSD_ADDR_UREG1:  rdata_reg <= {20'h00000, ureg_reg[1]};
        `CSD_ADDR_UREG2:  rdata_reg <= {20'h00000, ureg_reg[2]};
        default:          rdata_reg <= 32'h0000_0000;
      endcase
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_reg;

  //////////////////////////////////////////////////////////////////////////////
  a_float_means_ext: assert property (@(posedge ref_clk) disable iff (rst)
    (mode_valid && mode_code == csd_pkg::CSD_LVL_FLOAT) |=> ##1 extended_mode)
    else $error("floating mode pin did not give extended mode");

  a_driven_means_pin: assert property (@(posedge ref_clk) disable iff (rst)
    (mode_valid && mode_code != csd_pkg::CSD_LVL_FLOAT) |=> ##1 !extended_mode)
    else $error("driven mode pin did not give pin mode");

  a_range_from_pin: assert property (@(posedge ref_clk) disable iff (rst)
    (mode_reg == csd_pkg::CSD_MODE_PIN) |=>
      (input_full_scale_level == ($past(mode_code) == csd_pkg::CSD_LVL_HIGH)))
    else $error("input range does not follow mode pin");

  a_swing_from_pin: assert property (@(posedge ref_clk) disable iff (rst)
    (mode_reg == csd_pkg::CSD_MODE_PIN && straps_valid && swing_code != csd_pkg::CSD_LVL_FLOAT) |=>
      (output_swing_level == ($past(swing_code) == csd_pkg::CSD_LVL_HIGH)))
    else $error("swing does not follow swing pin");

  a_edge_from_pin: assert property (@(posedge ref_clk) disable iff (rst)
    (mode_reg == csd_pkg::CSD_MODE_PIN && straps_valid && edge_code != csd_pkg::CSD_LVL_FLOAT) |=>
      (!output_ddr_mode && output_launch_edge == ($past(edge_code) == csd_pkg::CSD_LVL_HIGH)))
    else $error("launch edge does not follow edge pin");

  a_ddr_on_float: assert property (@(posedge ref_clk) disable iff (rst)
    (mode_reg == csd_pkg::CSD_MODE_PIN && straps_valid && edge_code == csd_pkg::CSD_LVL_FLOAT) |=> output_ddr_mode)
    else $error("floating edge pin did not give double data rate");

  a_calibration_delay_select_from_pin: assert property (@(posedge ref_clk) disable iff (rst)
    (mode_reg == csd_pkg::CSD_MODE_PIN && straps_valid && cal_code == csd_pkg::CSD_LVL_FLOAT) |=>
      (fault_reg && $stable(calibration_delay_select)))
    else $error("floating delay pin not flagged or not ignored");

  a_cal_gated: assert property (@(posedge ref_clk) disable iff (rst)
    calibration_start |-> $past(config_valid) && (!extended_mode || written_reg == `CSD_UREG_ALL))
    else $error("calibration started before setup complete");

  a_fs_source: assert property (@(posedge ref_clk) disable iff (rst)
    (mode_reg == csd_pkg::CSD_MODE_EXT) ##1 (mode_reg == csd_pkg::CSD_MODE_EXT) |->
      full_scale_code == $past(ureg_reg[`CSD_UREG_FS]))
    else $error("full scale not taken from adjust register");

  c_pin_mode_valid: cover property (@(posedge ref_clk) disable iff (rst)
    !extended_mode && config_valid);
  c_ddr_mode: cover property (@(posedge ref_clk) disable iff (rst)
    !extended_mode && output_ddr_mode);
  c_serial_write: cover property (@(posedge ref_clk) disable iff (rst)
    ser_write);
  c_ext_calibrate: cover property (@(posedge ref_clk) disable iff (rst)
    extended_mode && calibration_start);

endmodule : csd_top
